// ===== core/sfm_frontend.sv
// Serial memory command front end with its receive FIFO

// ------------------------------------------------------------------
// Receive FIFO
// ------------------------------------------------------------------
module sfm_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // System
  input wire logic clk,
  input wire logic arst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem_q[rd_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sfm_fifo

// ------------------------------------------------------------------
// Command front end
// ------------------------------------------------------------------
module sfm_frontend
  import sfm_pkg::*;
#(
  parameter bit KEEP_LATCH_UPPER = 1'b1,
  parameter int BUF_DEPTH = FIFO_DEPTH
) (
  // System
  input wire logic clk,
  input wire logic arst_n,
  // Serial pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  output logic so_out,
  output logic so_oe,
  // Received address and data bytes
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [FIFO_WIDTH-1:0] rx_data,
  // Command and state
  output sfm_cmd_type cmd_code,
  output logic cmd_strobe,
  output logic top_address_bit,
  output logic mode3,
  output logic write_enable_flag,
  output logic [7:0] status,
  output logic drop_flag
);

  // ----------------------------------------------------------------
  // Opcode decoding
  // ----------------------------------------------------------------
  function automatic sfm_cmd_type decode(input logic [7:0] op);
    sfm_cmd_type c;
    c = CMD_NONE;
    if (op == OP_LATCH_SET) begin
      c = CMD_LATCH_SET;
    end else if (op == OP_LATCH_CLEAR) begin
      c = CMD_LATCH_CLEAR;
    end else if (op == OP_STATUS_READ) begin
      c = CMD_STATUS_READ;
    end else if (op == OP_STATUS_WRITE) begin
      c = CMD_STATUS_WRITE;
    end else if ((op & OP_MEM_MASK) == OP_MEM_READ) begin
      c = CMD_MEM_READ;
    end else if ((op & OP_MEM_MASK) == OP_MEM_WRITE) begin
      c = CMD_MEM_WRITE;
    end
    return c;
  endfunction : decode

  // ----------------------------------------------------------------
  // Pin synchronisers and edges
  // ----------------------------------------------------------------
  logic [1:0] cs_s;
  logic [1:0] sck_s;
  logic [1:0] si_s;
  logic cs_prev_q;
  logic sck_prev_q;
  logic cs_fall;
  logic cs_rise;
  logic active;
  logic sck_rise;
  logic sck_fall;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_s <= 2'h3;
      sck_s <= 2'h0;
      si_s <= 2'h0;
      cs_prev_q <= 1'b1;
      sck_prev_q <= 1'b0;
    end else begin
      cs_s <= {cs_s[0], cs_n};
      sck_s <= {sck_s[0], sck};
      si_s <= {si_s[0], si};
      cs_prev_q <= cs_s[1];
      sck_prev_q <= sck_s[1];
    end
  end

  assign cs_fall = cs_prev_q & ~cs_s[1];
  assign cs_rise = ~cs_prev_q & cs_s[1];
  assign active = ~cs_prev_q & ~cs_s[1];
  // Only a true low to high move counts, so a mode 3 idle high is no edge
  assign sck_rise = active & ~sck_prev_q & sck_s[1];
  assign sck_fall = active & sck_prev_q & ~sck_s[1];

  // ----------------------------------------------------------------
  // Mode detection
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode3 <= 1'b0;
    end else if (cs_fall) begin
      mode3 <= sck_s[1];
    end
  end

  // ----------------------------------------------------------------
  // Bit reception and command sequencing
  // ----------------------------------------------------------------
  sfm_state_type state_q;
  logic [2:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic [7:0] rx_byte;
  logic byte_done;
  logic op_done;
  sfm_cmd_type op_cmd;

  assign rx_byte = {shift_q, si_s[1]};
  assign byte_done = sck_rise & (bit_cnt_q == 3'h7);
  assign op_done = byte_done & (state_q == ST_OPCODE);
  assign op_cmd = decode(rx_byte);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt_q <= '0;
      shift_q <= '0;
    end else if (!active) begin
      bit_cnt_q <= '0;
    end else if (sck_rise) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q <= rx_byte[6:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
    end else if (cs_s[1]) begin
      state_q <= ST_IDLE;
    end else if (cs_fall) begin
      state_q <= ST_OPCODE;
    end else if (byte_done) begin
      case (state_q)
        ST_OPCODE: begin
          case (op_cmd)
            CMD_STATUS_READ: begin
              state_q <= ST_STATUS_OUT;
            end
            CMD_STATUS_WRITE: begin
              state_q <= ST_DATA;
            end
            CMD_MEM_READ, CMD_MEM_WRITE: begin
              state_q <= ST_ADDR;
            end
            default: begin
              state_q <= ST_IGNORE;
            end
          endcase
        end
        ST_ADDR: begin
          state_q <= ST_DATA;
        end
        default: begin
          state_q <= state_q;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_code <= CMD_NONE;
      top_address_bit <= 1'b0;
      cmd_strobe <= 1'b0;
    end else begin
      cmd_strobe <= op_done;
      if (op_done) begin
        cmd_code <= op_cmd;
        top_address_bit <= rx_byte[TOP_ADDR_POS];
      end
    end
  end

  // ----------------------------------------------------------------
  // Write enable latch and status register
  // ----------------------------------------------------------------
  logic [1:0] bp_q;
  logic clear_at_end;

  assign clear_at_end = (state_q != ST_OPCODE) && (state_q != ST_IDLE) &&
      ((cmd_code == CMD_LATCH_CLEAR) || (cmd_code == CMD_STATUS_WRITE) ||
      ((cmd_code == CMD_MEM_WRITE) && !(KEEP_LATCH_UPPER && top_address_bit)));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      write_enable_flag <= STATUS_RESET[WEF_POS];
    end else if (op_done && (op_cmd == CMD_LATCH_SET)) begin
      write_enable_flag <= 1'b1;
    end else if (cs_rise && clear_at_end) begin
      write_enable_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bp_q <= BP_RESET;
    end else if (byte_done && (state_q == ST_DATA) && (cmd_code == CMD_STATUS_WRITE) &&
        write_enable_flag) begin
      bp_q <= rx_byte[BP_HI_POS:BP_LO_POS];
    end
  end

  always_comb begin
    status = STATUS_RESET;
    status[WEF_POS] = write_enable_flag;
    status[BP_HI_POS:BP_LO_POS] = bp_q;
  end

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------
  logic [6:0] tx_q;
  logic [2:0] tx_cnt_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      so_out <= 1'b0;
      so_oe <= 1'b0;
      tx_q <= '0;
      tx_cnt_q <= '0;
    end else if (state_q != ST_STATUS_OUT) begin
      so_oe <= 1'b0;
      tx_cnt_q <= '0;
    end else if (sck_fall) begin
      so_oe <= 1'b1;
      tx_cnt_q <= tx_cnt_q + 3'h1;
      if (tx_cnt_q == 3'h0) begin
        so_out <= status[7];
        tx_q <= status[6:0];
      end else begin
        so_out <= tx_q[6];
        tx_q <= {tx_q[5:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // Received byte buffering
  // ----------------------------------------------------------------
  logic push;
  logic push_ready;

  assign push = byte_done && ((state_q == ST_ADDR) ||
      ((state_q == ST_DATA) && (cmd_code == CMD_MEM_WRITE) && write_enable_flag));

  sfm_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(BUF_DEPTH)) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .in_valid(push),
    .in_ready(push_ready),
    .in_data({state_q == ST_ADDR, rx_byte}),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  // Overflow is sticky until the next select; a new loss wins over the clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      drop_flag <= 1'b0;
    end else if (push && !push_ready) begin
      drop_flag <= 1'b1;
    end else if (cs_fall) begin
      drop_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  oe_deselect_a: assert property (cs_s[1] && (state_q == ST_IDLE) |=> !so_oe)
    else $error("output driven while deselected");
  invalid_op_a: assert property (op_done && (op_cmd == CMD_NONE) |=>
      (state_q == ST_IGNORE) && !so_oe)
    else $error("invalid opcode not ignored");
  latch_set_a: assert property (op_done && (rx_byte == OP_LATCH_SET) |=>
      write_enable_flag && status[WEF_POS])
    else $error("latch not set by set command");
  latch_clear_a: assert property (cs_rise && (state_q == ST_IGNORE) &&
      (cmd_code == CMD_LATCH_CLEAR) |=> !write_enable_flag)
    else $error("latch not cleared");
  upper_keep_a: assert property (cs_rise && (state_q == ST_DATA) && KEEP_LATCH_UPPER &&
      (cmd_code == CMD_MEM_WRITE) && top_address_bit && write_enable_flag |=>
      write_enable_flag)
    else $error("latch cleared after upper write");
  abort_a: assert property (cs_s[1] |=> (state_q == ST_IDLE) ##1
      (bit_cnt_q == 3'h0))
    else $error("deselect did not abort");
  mode_pick_a: assert property (cs_fall |=> mode3 == $past(sck_s[1]))
    else $error("mode not taken at select");
  partial_op_a: assert property (cs_rise && (state_q == ST_OPCODE) |=>
      $stable(write_enable_flag) && !cmd_strobe)
    else $error("partial opcode had effect");
  status_first_a: assert property ((state_q == ST_STATUS_OUT) && sck_fall |=>
      so_oe && (so_out == $past(status[3'h7 - tx_cnt_q])))
    else $error("status byte bit wrong");

  mode3_c: cover property (cs_fall && sck_s[1]);
  set_c: cover property (op_done && (op_cmd == CMD_LATCH_SET));
  status_c: cover property ((state_q == ST_STATUS_OUT) && (tx_cnt_q == 3'h7) && sck_fall);
  drop_c: cover property (push && !push_ready);

endmodule : sfm_frontend

// ===== core/sfm_pkg.sv
// Constants and types of the serial memory command front end
package sfm_pkg;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_MEM_MASK = 8'hf7;
  localparam logic [7:0] OP_MEM_READ = 8'h03;
  localparam logic [7:0] OP_MEM_WRITE = 8'h02;
  localparam int TOP_ADDR_POS = 3;

  // ----------------------------------------------------------------
  // Status register layout
  // ----------------------------------------------------------------
  localparam int WEF_POS = 1;
  localparam int BP_LO_POS = 2;
  localparam int BP_HI_POS = 3;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [1:0] BP_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Link and buffer figures
  // ----------------------------------------------------------------
  localparam int SCK_MAX_MHZ = 20;
  localparam int BYTE_BITS = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 9;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NONE, CMD_LATCH_SET, CMD_LATCH_CLEAR, CMD_STATUS_READ,
    CMD_STATUS_WRITE, CMD_MEM_READ, CMD_MEM_WRITE
  } sfm_cmd_type;

  typedef enum {
    ST_IDLE, ST_OPCODE, ST_ADDR, ST_DATA, ST_STATUS_OUT, ST_IGNORE
  } sfm_state_type;

endpackage : sfm_pkg

// ===== bench/sfm_spi_master.sv
// Serial bus master model driving the front end pins
module sfm_spi_master (
  // System
  input wire logic clk,
  // Serial pins
  output logic cs_n,
  output logic sck,
  output logic si,
  input wire logic so_out,
  input wire logic so_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  logic cpol = 1'b0;
  int slow = 0;

  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // Select with the clock parked at the mode level
  task automatic start(input logic m3);
    cpol = m3;
    sck <= m3;
    tick(2);
    cs_n <= 1'b0;
    tick(3);
  endtask : start

  // Shift n bits of tx, capture serial out before each rise
  task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      if (cpol) sck <= 1'b0;
      si <= tx[i];
      tick(5 + slow);
      rx[i] = so_oe ? so_out : 1'bz;
      sck <= 1'b1;
      tick(3);
      if (!cpol) sck <= 1'b0;
    end
  endtask : bits

  // Deselect; data line stops showing the last bit
  task automatic stop();
    tick(2);
    cs_n <= 1'b1;
    si <= ~si;
    tick(6);
  endtask : stop

  // Clock and data activity while deselected
  task automatic noise();
    repeat (16) begin
      sck <= ~sck;
      si <= ~si;
      tick(4);
    end
  endtask : noise
endmodule : sfm_spi_master

// ===== bench/tb_sfm_frontend.sv
// Self-checking bench of the serial memory command front end
module tb_sfm_frontend
  import sfm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

`define CHK(nm, e, g) \
  begin \
    check_count++; \
    if ((g) !== (e)) begin \
      failures++; \
      $display("wrong value %s expected %h seen %h", nm, e, g); \
    end \
  end

  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic rx_ready = 1'b1;
  logic cs_n, sck, si, so_out, so_oe, rx_valid, cmd_strobe, top_address_bit, mode3;
  logic write_enable_flag, drop_flag;
  logic [8:0] rx_data;
  logic [7:0] status, rd;
  sfm_cmd_type cmd_code;
  int failures = 0;
  int check_count = 0;
  int strobes = 0;
  logic [8:0] got_q[$];

  always #10 clk = ~clk;

  sfm_frontend dut (
    .clk(clk), .arst_n(arst_n), .cs_n(cs_n), .sck(sck), .si(si), .so_out(so_out),
    .so_oe(so_oe), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .cmd_code(cmd_code), .cmd_strobe(cmd_strobe), .top_address_bit(top_address_bit),
    .mode3(mode3), .write_enable_flag(write_enable_flag), .status(status),
    .drop_flag(drop_flag)
  );

  sfm_spi_master mst (
    .clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so_out(so_out), .so_oe(so_oe)
  );

  // Strobe count and drained words
  always @(posedge clk) begin
    if (cmd_strobe === 1'b1) strobes++;
    if (rx_valid === 1'b1 && rx_ready === 1'b1) got_q.push_back(rx_data);
  end

  task automatic b(input logic [7:0] v);
    mst.bits(v, 8, rd);
  endtask : b

  task automatic one(input logic [7:0] op);
    mst.start(1'b0);
    b(op);
    mst.stop();
  endtask : one

  task automatic rdst(input logic m3, output logic [7:0] v);
    mst.start(m3);
    b(OP_STATUS_READ);
    mst.bits(8'h00, 8, v);
    mst.stop();
  endtask : rdst

  task automatic drain(input int n);
    int k;
    k = 0;
    while (got_q.size() < n && k < 60) begin
      @(posedge clk);
      k++;
    end
    if (got_q.size() < n) begin
      failures++;
      summarize();
    end
  endtask : drain

  task automatic t_reset();
    `CHK("status", 8'h00, status)
    `CHK("latch", 1'b0, write_enable_flag)
    `CHK("cmd", CMD_NONE, cmd_code)
    `CHK("so_oe", 1'b0, so_oe)
    $display("test reset done");
  endtask : t_reset

  task automatic t_latch();
    int s0;
    s0 = strobes;
    one(OP_LATCH_SET);
    `CHK("latch", 1'b1, write_enable_flag)
    `CHK("cmd", CMD_LATCH_SET, cmd_code)
    `CHK("mode3", 1'b0, mode3)
    `CHK("strobes", s0 + 1, strobes)
    rdst(1'b1, rd);
    `CHK("status read", 8'h02, rd)
    `CHK("mode3", 1'b1, mode3)
    `CHK("so_oe", 1'b0, so_oe)
    one(OP_LATCH_CLEAR);
    `CHK("latch", 1'b0, write_enable_flag)
    rdst(1'b0, rd);
    `CHK("status read", 8'h00, rd)
    `CHK("cmd", CMD_STATUS_READ, cmd_code)
    $display("test latch done");
  endtask : t_latch

  task automatic t_wrst();
    mst.start(1'b0);
    b(OP_STATUS_WRITE);
    b(8'h0c);
    mst.stop();
    `CHK("status", 8'h00, status)
    one(OP_LATCH_SET);
    mst.start(1'b0);
    b(OP_STATUS_WRITE);
    b(8'h0c);
    `CHK("latch", 1'b1, write_enable_flag)
    `CHK("cmd", CMD_STATUS_WRITE, cmd_code)
    mst.stop();
    `CHK("status", 8'h0c, status)
    one(OP_LATCH_SET);
    mst.start(1'b1);
    b(OP_STATUS_WRITE);
    b(8'h00);
    mst.stop();
    `CHK("status", 8'h00, status)
    $display("test status write done");
  endtask : t_wrst

  task automatic t_mem();
    got_q.delete();
    one(OP_LATCH_SET);
    mst.start(1'b0);
    b(OP_MEM_WRITE);
    b(8'h34);
    b(8'ha5);
    `CHK("top bit", 1'b0, top_address_bit)
    `CHK("cmd", CMD_MEM_WRITE, cmd_code)
    mst.stop();
    `CHK("latch", 1'b0, write_enable_flag)
    one(OP_LATCH_SET);
    mst.start(1'b0);
    b(OP_MEM_WRITE | 8'h08);
    b(8'h77);
    mst.stop();
    `CHK("top bit", 1'b1, top_address_bit)
    `CHK("latch", 1'b1, write_enable_flag)
    mst.start(1'b1);
    b(OP_MEM_READ | 8'h08);
    b(8'h10);
    b(8'h00);
    `CHK("cmd", CMD_MEM_READ, cmd_code)
    `CHK("so_oe", 1'b0, so_oe)
    mst.stop();
    drain(4);
    `CHK("rx 0", 9'h134, got_q[0])
    `CHK("rx 1", 9'h0a5, got_q[1])
    `CHK("rx 2", 9'h177, got_q[2])
    `CHK("rx 3", 9'h110, got_q[3])
    one(OP_LATCH_CLEAR);
    $display("test memory done");
  endtask : t_mem

  task automatic t_bad();
    int s0;
    got_q.delete();
    s0 = strobes;
    mst.start(1'b0);
    b(8'hff);
    b(OP_LATCH_SET);
    b(8'h12);
    `CHK("so_oe", 1'b0, so_oe)
    mst.stop();
    `CHK("latch", 1'b0, write_enable_flag)
    `CHK("rx count", 0, got_q.size())
    mst.start(1'b0);
    mst.bits(OP_LATCH_SET, 7, rd);
    mst.stop();
    `CHK("latch", 1'b0, write_enable_flag)
    one(OP_LATCH_SET);
    `CHK("latch", 1'b1, write_enable_flag)
    s0 = strobes;
    mst.noise();
    `CHK("strobes", s0, strobes)
    `CHK("latch", 1'b1, write_enable_flag)
    $display("test refusal done");
  endtask : t_bad

  task automatic t_fifo();
    got_q.delete();
    rx_ready <= 1'b0;
    mst.slow = 4;
    mst.start(1'b0);
    b(OP_MEM_WRITE);
    b(8'h00);
    for (int i = 1; i <= 9; i++) b(8'(i));
    mst.stop();
    `CHK("drop", 1'b1, drop_flag)
    `CHK("rx valid", 1'b1, rx_valid)
    rx_ready <= 1'b1;
    mst.slow = 0;
    drain(8);
    mst.tick(10);
    `CHK("rx count", 8, got_q.size())
    `CHK("rx 0", 9'h100, got_q[0])
    for (int i = 1; i < 8; i++) `CHK("rx", 9'(i), got_q[i])
    `CHK("latch", 1'b0, write_enable_flag)
    $display("test fifo done");
  endtask : t_fifo

  task automatic summarize();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  initial begin
    #1ms;
    failures++;
    summarize();
  end

  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_latch();
    t_wrst();
    t_mem();
    t_bad();
    t_fifo();
    summarize();
  end
endmodule : tb_sfm_frontend
